// ### hw/async_port_pkg.sv
/*
 Shared constants and types for the asynchronous 16-bit host bus port.
 Assumes both ends run on one 250 MHz clock.
*/
package async_port_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_PS = 4000;
   // Read data is presented one cycle before acknowledge is driven
   localparam int RD_SETUP_CYC = 1;
   localparam logic [3:0] CS_FIELD_HI = 4'hf;
   localparam logic [3:0] CS_FIELD_LO = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   // Host gives up after this many cycles plus one without acknowledge
   localparam int HOST_TIMEOUT_CYC = 255;
   typedef enum logic [1:0] {DEV_IDLE, DEV_SETUP, DEV_ACK} dev_state_t;
   typedef enum logic [1:0] {HST_IDLE, HST_WAIT, HST_END} hst_state_t;
endpackage : async_port_pkg

// ### hw/async_port_if.sv
/*
 Interface joining the device end and the host end of the bus port.
 Resolves the shared data bus from the two output enables.
*/
`timescale 1ns/1ps
interface async_port_if;
   import async_port_pkg::*;
   logic addr_strobe_n;
   logic data_strobe;
   logic read_not_write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] host_data;
   logic host_data_oe;
   logic [DATA_W-1:0] dev_data;
   logic dev_data_oe;
   logic [DATA_W-1:0] data_bus;
   logic xfer_ack_n;
   logic irq_pin_a;
   logic cpu_irq_level_in;
   logic high_byte_sel_n;
   logic addr_latch_strobe;
   assign data_bus = dev_data_oe ? dev_data :
                     (host_data_oe ? host_data : DATA_RST);
   assign cpu_irq_level_in = irq_pin_a;
   assign high_byte_sel_n = 1'b0;
   // No ROM read command runs on this carrier; the pin is held high
   assign addr_latch_strobe = 1'b1;
   modport device (
      input addr_strobe_n, data_strobe, read_not_write, addr, data_bus,
      input high_byte_sel_n, addr_latch_strobe,
      output dev_data, dev_data_oe, xfer_ack_n, irq_pin_a
   );
   modport host (
      output addr_strobe_n, data_strobe, read_not_write, addr,
      output host_data, host_data_oe,
      input data_bus, xfer_ack_n, cpu_irq_level_in
   );
endinterface : async_port_if

// ### hw/async_host_bus_port.sv
/*
 Device end of the asynchronous 16-bit host bus port.
 Assumes host strobes arrive asynchronously; they are synchronised here.
*/
`timescale 1ns/1ps
module async_host_bus_port #(
   parameter int AW = async_port_pkg::ADDR_W
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   async_port_if.device bus,
   input wire logic irq_req_in,
   input wire logic [async_port_pkg::DATA_W-1:0] rd_data_in,
   output logic [AW-1:0] acc_addr_out,
   output logic [async_port_pkg::DATA_W-1:0] wr_data_out,
   output logic wr_pulse_out,
   output logic rd_pulse_out,
   output logic wait_ready_out,
   output logic wait_ready_oe_out,
   output logic word_select_out,
   output logic word_select_oe_out,
   output logic irq_pin_b_out,
   output logic irq_pin_c_out
);
   import async_port_pkg::*;

   // Below five bits the word offset has no room left to decode
   if (AW < 5 || AW > ADDR_W)
   begin : g_bad_aw
      $error("AW out of range");
   end

   typedef struct packed {
      logic [1:0] as_sync;
      logic [1:0] ds_sync;
      logic [1:0] rw_sync;
      dev_state_t st;
      logic [AW-1:0] addr;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] wdata;
      logic drive;
      logic ack;
      logic wr;
      logic rd;
      logic irq;
   } dev_regs_t;

   // Synchronisers start at the idle levels of their pins, so no false
   // cycle is seen as reset lifts
   localparam dev_regs_t DEV_RST = '{
      as_sync: 2'b11,
      ds_sync: 2'b00,
      rw_sync: 2'b11,
      st: DEV_IDLE,
      addr: '0,
      rdata: DATA_RST,
      wdata: DATA_RST,
      drive: 1'b0,
      ack: 1'b0,
      wr: 1'b0,
      rd: 1'b0,
      irq: 1'b0
   };

   // Shifts one pin sample into a two-stage synchroniser
   function automatic logic [1:0] sync_push(
      input logic [1:0] stages,
      input logic pin
   );
      return {stages[0], pin};
   endfunction : sync_push

   // A cycle stands while the settled address strobe is low and the
   // settled data strobe is high
   function automatic logic cycle_seen(
      input logic [1:0] as_stages,
      input logic [1:0] ds_stages
   );
      return !as_stages[1] && ds_stages[1];
   endfunction : cycle_seen

   // Direction is trusted only from the settled stage
   function automatic logic read_seen(input logic [1:0] rw_stages);
      return rw_stages[1];
   endfunction : read_seen

   // One registered copy of all state; nxt is its next value
   dev_regs_t r;
   dev_regs_t nxt;
   logic cyc_on;

   always_comb
   begin
      nxt = r;
      cyc_on = 1'b0;
      // Sample pins first; only the last stage feeds any decision
      nxt.as_sync = sync_push(r.as_sync, bus.addr_strobe_n);
      nxt.ds_sync = sync_push(r.ds_sync, bus.data_strobe);
      nxt.rw_sync = sync_push(r.rw_sync, bus.read_not_write);

      // Core strobes are one-cycle pulses
      nxt.wr = 1'b0;
      nxt.rd = 1'b0;

      nxt.irq = irq_req_in;

      // Both strobes must be seen after sync before any decode
      cyc_on = cycle_seen(r.as_sync, r.ds_sync);

      case (r.st)
         DEV_IDLE:
         begin
            nxt.ack = 1'b0;
            nxt.drive = 1'b0;
            if (cyc_on)
            begin
               nxt.addr = bus.addr[AW-1:0];
               if (read_seen(r.rw_sync))
               begin
                  nxt.rd = 1'b1;
                  nxt.st = DEV_SETUP;
               end
               else
               begin
                  // Bus settled: strobes passed two flops
                  nxt.wdata = bus.data_bus;
                  nxt.wr = 1'b1;
                  nxt.ack = 1'b1;
                  nxt.st = DEV_ACK;
               end
            end
         end
         DEV_SETUP:
         begin
            // Data settles a full cycle before acknowledge, so the host
            // never latches a bus that is still turning round
            nxt.rdata = rd_data_in;
            nxt.drive = 1'b1;
            nxt.st = DEV_ACK;
         end
         DEV_ACK:
         begin
            // Held until either strobe is seen released
            nxt.ack = 1'b1;
            if (!cyc_on)
            begin
               nxt.ack = 1'b0;
               nxt.drive = 1'b0;
               nxt.st = DEV_IDLE;
            end
         end
         default:
            nxt.st = DEV_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         r <= DEV_RST;
      end
      else if (clk_en_in)
      begin
         // Low enable freezes every stage, synchronisers included
         r <= nxt;
      end
   end

   // Bus side
   assign bus.xfer_ack_n = !r.ack;
   assign bus.dev_data = r.rdata;
   assign bus.dev_data_oe = r.drive;
   assign bus.irq_pin_a = r.irq;

   // Core side
   assign acc_addr_out = r.addr;
   assign wr_data_out = r.wdata;
   assign wr_pulse_out = r.wr;
   assign rd_pulse_out = r.rd;

   // Retired pins are released with their enables low; the spare interrupt pins are driven low
   assign wait_ready_out = 1'b0;
   assign wait_ready_oe_out = 1'b0;
   assign word_select_out = 1'b0;
   assign word_select_oe_out = 1'b0;
   assign irq_pin_b_out = 1'b0;
   assign irq_pin_c_out = 1'b0;
endmodule : async_host_bus_port

// ### hw/async_bus_host.sv
/*
 Host end of the asynchronous 16-bit bus port.
 Assumes the device answers with an active-low acknowledge.
*/
`timescale 1ns/1ps
module async_bus_host (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   async_port_if.host bus,
   input wire logic req_in,
   input wire logic req_read_in,
   input wire logic [async_port_pkg::ADDR_W-1:0] req_addr_in,
   input wire logic [async_port_pkg::DATA_W-1:0] req_wdata_in,
   output logic req_ready_out,
   output logic done_out,
   output logic timeout_out,
   output logic [async_port_pkg::DATA_W-1:0] rdata_out,
   output logic irq_out
);
   import async_port_pkg::*;

   typedef struct packed {
      logic [1:0] ack_sync;
      logic [1:0] irq_sync;
      hst_state_t st;
      logic as_n;
      logic ds;
      logic rnw;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic drive;
      logic [DATA_W-1:0] rdata;
      logic done;
      logic tmo;
      logic [7:0] cnt;
   } hst_regs_t;

   hst_regs_t r, nxt;

   always_comb
   begin
      nxt = r;
      nxt.ack_sync = {r.ack_sync[0], bus.xfer_ack_n};
      nxt.irq_sync = {r.irq_sync[0], bus.cpu_irq_level_in};
      nxt.done = 1'b0;
      nxt.tmo = 1'b0;
      case (r.st)
         HST_IDLE:
            if (req_in)
            begin
               nxt.addr = req_addr_in;
               nxt.rnw = req_read_in;
               nxt.wdata = req_wdata_in;
               nxt.drive = !req_read_in;
               nxt.as_n = 1'b0;
               nxt.ds = 1'b1;
               nxt.cnt = 8'h00;
               nxt.st = HST_WAIT;
            end
         HST_WAIT:
         begin
            nxt.cnt = r.cnt + 8'h01;
            if (!r.ack_sync[1])
            begin
               if (r.rnw)
                  nxt.rdata = bus.data_bus;
               nxt.done = 1'b1;
               nxt.as_n = 1'b1;
               nxt.ds = 1'b0;
               nxt.st = HST_END;
            end
            else if (r.cnt == 8'(HOST_TIMEOUT_CYC))
            begin
               nxt.tmo = 1'b1;
               nxt.as_n = 1'b1;
               nxt.ds = 1'b0;
               nxt.st = HST_END;
            end
         end
         HST_END:
         begin
            // Wait for acknowledge to drop before a new cycle
            nxt.drive = 1'b0;
            if (r.ack_sync[1])
               nxt.st = HST_IDLE;
         end
         default:
            nxt.st = HST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         r <= '{ack_sync: 2'b11, irq_sync: 2'b00, st: HST_IDLE,
                as_n: 1'b1, ds: 1'b0, rnw: 1'b1, addr: ADDR_RST,
                wdata: DATA_RST, drive: 1'b0, rdata: DATA_RST,
                done: 1'b0, tmo: 1'b0, cnt: 8'h00};
      end
      else if (clk_en_in)
      begin
         r <= nxt;
      end
   end

   assign bus.addr_strobe_n = r.as_n;
   assign bus.data_strobe = r.ds;
   assign bus.read_not_write = r.rnw;
   assign bus.addr = r.addr;
   assign bus.host_data = r.wdata;
   assign bus.host_data_oe = r.drive;
   assign req_ready_out = (r.st == HST_IDLE);
   assign done_out = r.done;
   assign timeout_out = r.tmo;
   assign rdata_out = r.rdata;
   assign irq_out = r.irq_sync[1];
endmodule : async_bus_host

// ### testbench/async_port_props.sv
/*
 Bus-side checks of the device end of the host bus port.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module async_port_props (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic addr_strobe_n,
   input wire logic data_strobe,
   input wire logic read_not_write,
   input wire logic dev_data_oe,
   input wire logic xfer_ack_n
);
   default clocking @(posedge sys_clk_in);
   endclocking
   // A frozen device answers nothing, so its cycles are not judged
   default disable iff (!rst_n_in || !clk_en_in);
   sequence cyc_open;
      $fell(addr_strobe_n) && data_strobe;
   endsequence
   sequence ack_start;
      $fell(xfer_ack_n);
   endsequence
   ack_as_a: assert property (ack_start |-> !addr_strobe_n)
      else $error("ack without address strobe");
   ack_ds_a: assert property (ack_start |-> data_strobe)
      else $error("ack without data strobe");
   read_drive_a: assert property (
      ack_start ##0 read_not_write |-> dev_data_oe)
      else $error("read ack with bus undriven");
   write_quiet_a: assert property (
      ack_start ##0 !read_not_write |-> !dev_data_oe)
      else $error("device drives bus on write");
   read_setup_a: assert property (
      ack_start ##0 read_not_write |-> $past(dev_data_oe))
      else $error("read data not set up before ack");
   ack_answer_a: assert property (
      cyc_open |-> ##[1:12] !xfer_ack_n)
      else $error("no ack for cycle");
   ack_hold_a: assert property (
      !xfer_ack_n && !addr_strobe_n |=> !xfer_ack_n)
      else $error("ack dropped inside cycle");
   ack_drop_a: assert property (
      $rose(addr_strobe_n) |-> ##[1:8] xfer_ack_n)
      else $error("ack not released");
   data_release_a: assert property (
      $rose(xfer_ack_n) |=> !dev_data_oe)
      else $error("data bus not released");
endmodule : async_port_props

// ### testbench/test_async_host_bus_port.sv
/*
 Testbench joining the host end and the device end of the port.
 Assumes the package constants; clock 250 MHz.
*/
`timescale 1ns/1ps
module test_async_host_bus_port;
   import async_port_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic irq_req = 1'b0;
   logic req = 1'b0;
   logic req_read = 1'b0;
   logic [DATA_W-1:0] rd_data = 16'h0000;
   logic [ADDR_W-1:0] req_addr = 16'h0000;
   logic [DATA_W-1:0] req_wdata = 16'h0000;
   logic req_ready, done, irq, wr_pulse, rd_pulse, timeout;
   logic dev_en = 1'b1;
   int n_cyc = 0;
   logic [DATA_W-1:0] rdata, wr_data;
   logic [ADDR_W-1:0] acc_addr;
   logic [5:0] spare;
   logic [15:0] tbl [3] = '{16'h0000, 16'ha5c3, 16'hffff};
   int n_fail = 0;
   int num_checks = 0;
   int n_wr = 0;
   int n_rd = 0;
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      n_wr += int'(wr_pulse === 1'b1);
      n_rd += int'(rd_pulse === 1'b1);
   end
   async_port_if i_async_port_if ();
   async_host_bus_port i_async_host_bus_port (.sys_clk_in(sys_clk),
      .rst_n_in(rst_n), .clk_en_in(dev_en), .bus(i_async_port_if),
      .irq_req_in(irq_req), .rd_data_in(rd_data), .acc_addr_out(acc_addr),
      .wr_data_out(wr_data), .wr_pulse_out(wr_pulse),
      .rd_pulse_out(rd_pulse), .wait_ready_out(spare[4]),
      .wait_ready_oe_out(spare[0]), .word_select_out(spare[5]),
      .word_select_oe_out(spare[1]), .irq_pin_b_out(spare[2]),
      .irq_pin_c_out(spare[3]));
   async_bus_host i_async_bus_host (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
      .clk_en_in(1'b1), .bus(i_async_port_if), .req_in(req),
      .req_read_in(req_read), .req_addr_in(req_addr),
      .req_wdata_in(req_wdata), .req_ready_out(req_ready),
      .done_out(done), .timeout_out(timeout), .rdata_out(rdata),
      .irq_out(irq));
   async_port_props i_async_port_props (.sys_clk_in(sys_clk),
      .rst_n_in(rst_n),
      .clk_en_in(dev_en),
      .addr_strobe_n(i_async_port_if.addr_strobe_n),
      .data_strobe(i_async_port_if.data_strobe),
      .read_not_write(i_async_port_if.read_not_write),
      .dev_data_oe(i_async_port_if.dev_data_oe),
      .xfer_ack_n(i_async_port_if.xfer_ack_n));
   task automatic chk(input string name, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   function automatic logic cond(input int sel);
      case (sel)
         0: return done === 1'b1;
         1: return req_ready === 1'b1 && i_async_port_if.xfer_ack_n === 1'b1;
         default: return irq === irq_req;
      endcase
   endfunction : cond
   // Bounded wait; a hang ends the run through the closing report
   task automatic wait_for(input int sel);
      int i;
      for (i = 0; i < 40 && !cond(sel); i++)
         @(posedge sys_clk) #1;
      if (i == 40)
      begin
         n_fail++;
         $display("unexpected timeout on wait %0d", sel);
         wrap_up();
      end
   endtask : wait_for
   task automatic xfer(input logic rd, input logic [15:0] a, d);
      req_read = rd;
      req_addr = a;
      req_wdata = d;
      req = 1'b1;
      @(posedge sys_clk) #1;
      req = 1'b0;
      wait_for(0);
      chk("address", acc_addr, a);
      if (rd)
         chk("read data", rdata, rd_data);
      else
         chk("write data", wr_data, d);
      wait_for(1);
   endtask : xfer
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      chk("unused pins", {10'h000, spare}, 16'h0000);
      // Zero, mixed-bit and all-ones addresses, write then read back to back
      for (int k = 0; k < 3; k++)
      begin
         xfer(1'b0, tbl[k], ~tbl[k]);
         rd_data = tbl[k] ^ 16'h3c5a;
         xfer(1'b1, tbl[k], 16'h0000);
         chk("writes", 16'(n_wr), 16'(k + 1));
         chk("reads", 16'(n_rd), 16'(k + 1));
      end
      $display("test transfers done");
      for (int v = 1; v >= 0; v--)
      begin
         irq_req = v[0];
         wait_for(2);
         chk("irq", 16'(i_async_port_if.cpu_irq_level_in),
            16'(v));
      end
      $display("test interrupt done");
      // Frozen device never answers; the host must give up on its own
      dev_en = 1'b0;
      req_read = 1'b1;
      req = 1'b1;
      @(posedge sys_clk) #1;
      req = 1'b0;
      n_cyc = 0;
      while (timeout !== 1'b1 && n_cyc < 300)
      begin
         @(posedge sys_clk) #1;
         n_cyc++;
      end
      chk("tmo cycles", 16'(n_cyc), 16'(HOST_TIMEOUT_CYC + 1));
      chk("frozen ack", 16'(i_async_port_if.xfer_ack_n), 16'h0001);
      if (n_cyc >= 300)
         wrap_up();
      dev_en = 1'b1;
      wait_for(1);
      $display("test frozen device done");
      req_read = 1'b1;
      req = 1'b1;
      @(posedge sys_clk) #1;
      req = 1'b0;
      repeat (4) @(posedge sys_clk) #1;
      rst_n = 1'b0;
      #1 chk("reset idle", {14'h0000, i_async_port_if.xfer_ack_n,
         i_async_port_if.dev_data_oe}, 16'h0002);
      @(posedge sys_clk) #1 rst_n = 1'b1;
      xfer(1'b0, 16'h0010, 16'hbeef);
      chk("writes", 16'(n_wr), 16'h0004);
      $display("test reset abort done");
      wrap_up();
   end
endmodule : test_async_host_bus_port
